// ---- bench/aops_host_model.sv ----
/* host model: drives select and read, reads a word after each ready fall once word_settled is high.
   assumes the bench sets cs_req and rd_req; one clock, clk_sys. */
module aops_host_model (
  input  wire logic        clk_sys,
  input  wire logic        cs_req,
  input  wire logic        rd_req,
  input  wire logic [15:0] word_out,
  input  wire logic [15:0] word_oe_n,
  input  wire logic        word_ready_strobe_n,
  input  wire logic        over_range_flag,
  input  wire logic        word_settled,
  output logic             chip_select_n,
  output logic             read_enable_n,
  output logic [15:0]      got_word,
  output logic             got_flag,
  output int               n_falls
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        strobe_q;
  logic [15:0] last;
  logic [15:0] bus_lvl;
  // released bits float: show the inverse of the last level, not a copy
  always_comb for (int i = 0; i < 16; i++) bus_lvl[i] = word_oe_n[i] ? ~last[i] : word_out[i];
  initial begin
    n_falls = 0;
  end
  // requests follow the bench, which changes them off the sampling edge
  always_comb begin
    chip_select_n = ~cs_req;
    read_enable_n = ~rd_req;
  end
  // read after the fall; words before settling are thrown away
  always @(posedge clk_sys) begin
    strobe_q <= word_ready_strobe_n;
    last <= bus_lvl;
    if (strobe_q && !word_ready_strobe_n) begin
      n_falls <= n_falls + 1;
      if (word_settled) begin
        got_word <= bus_lvl;
        got_flag <= over_range_flag;
      end
    end
  end
endmodule

// ---- bench/aops_seq_asserts.sv ----
/* port checker for aops_seq. assumes one clock; bound to every instance. */
module aops_seq_chk
  import aops_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        sync_n,
  input wire logic        power_down_n,
  input wire logic        chip_select_n,
  input wire logic        read_enable_n,
  input wire logic [15:0] word_out,
  input wire logic [15:0] word_oe_n,
  input wire logic        word_ready_strobe_n,
  input wire logic        over_range_flag,
  input wire logic        word_settled
);
  timeunit 1ns;
  timeprecision 1ps;
  // power-down restarts the strobe, so its cycles are excused
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !sync_n || !power_down_n);
  property p_oe_off; chip_select_n || read_enable_n |=> word_oe_n == 16'hFFFF; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
  property p_oe_on; !chip_select_n && !read_enable_n |=> word_oe_n == 16'h0000; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  property p_low3;
    $fell(word_ready_strobe_n) |-> !word_ready_strobe_n [*3] ##1 word_ready_strobe_n;
  endproperty
  a_low3: assert property (p_low3) else $error("ready low phase length");
  property p_high3; $rose(word_ready_strobe_n) |-> word_ready_strobe_n [*3] ##1 !word_ready_strobe_n; endproperty
  a_high3: assert property (p_high3) else $error("ready high phase length");
  property p_first; $rose(sync_n) |-> word_ready_strobe_n [*2] ##1 !word_ready_strobe_n; endproperty
  a_first: assert property (p_first) else $error("first ready fall late");
  property p_flag; !$fell(word_ready_strobe_n) |-> $stable(over_range_flag); endproperty
  a_flag: assert property (p_flag) else $error("flag moved off fall");
  property p_word; !$fell(word_ready_strobe_n) |-> $stable(word_out); endproperty
  a_word: assert property (p_word) else $error("word moved off fall");
  property p_clip; over_range_flag |-> word_out == CODE_MAX || word_out == CODE_MIN; endproperty
  a_clip: assert property (p_clip) else $error("flag without clip");
  property p_zero;
    @(posedge clk_sys) disable iff (!rst_n) !sync_n |-> word_out == CODE_ZERO && word_ready_strobe_n;
  endproperty
  a_zero: assert property (p_zero) else $error("sync not clearing");
  c_clip: cover property (over_range_flag);
  c_drive: cover property (word_oe_n == 16'h0000);
  c_settle: cover property ($rose(word_settled));
endmodule
bind aops_seq aops_seq_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sync_n(sync_n),
  .power_down_n(power_down_n), .chip_select_n(chip_select_n), .read_enable_n(read_enable_n),
  .word_out(word_out), .word_oe_n(word_oe_n), .word_ready_strobe_n(word_ready_strobe_n),
  .over_range_flag(over_range_flag), .word_settled(word_settled));

// ---- bench/test_adc_output_port_sequencer.sv ----
/* self-checking bench for aops_seq with the host model on the bus.
   assumes a 200 MHz clk_sys; inputs change on the falling edge. */
module test_adc_output_port_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import aops_pkg::*;
  logic               clk_sys, rst_n, sync_n, power_down_n, cs_req, rd_req;
  logic signed [15:0] mod_sample;
  logic               chip_select_n, read_enable_n, strobe_n, flag, settled, saving, got_flag;
  logic [15:0]        word_out, word_oe_n, got_word;
  int                 n_falls, err_count, n_checks;
  // wide samples so that a six-sum can pass full scale
  aops_seq #(.SAMPLE_W(16)) u_aops_seq (.clk_sys(clk_sys), .rst_n(rst_n), .sync_n(sync_n),
    .power_down_n(power_down_n), .mod_sample(mod_sample), .chip_select_n(chip_select_n),
    .read_enable_n(read_enable_n), .word_out(word_out), .word_oe_n(word_oe_n),
    .word_ready_strobe_n(strobe_n), .over_range_flag(flag), .word_settled(settled),
    .power_saving(saving));
  aops_host_model u_aops_host_model (.clk_sys(clk_sys), .cs_req(cs_req), .rd_req(rd_req),
    .word_out(word_out), .word_oe_n(word_oe_n), .word_ready_strobe_n(strobe_n),
    .over_range_flag(flag), .word_settled(settled), .chip_select_n(chip_select_n),
    .read_enable_n(read_enable_n), .got_word(got_word), .got_flag(got_flag), .n_falls(n_falls));
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait for n ready falls
  task automatic wait_falls(int n);
    int t;
    t = n_falls + n;
    for (int k = 0; k < n * 6 + 60 && n_falls < t; k++) @(negedge clk_sys);
    if (n_falls < t) begin
      err_count++;
      $display("FAIL strobe timeout");
      final_report();
    end
  endtask
  task automatic t_settle();
    int k;
    mod_sample = 16'sh0001;
    sync_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("zero", word_out, CODE_ZERO);
    chk("strobe", {15'h0, strobe_n}, 16'h0001);
    sync_n = 1'b1;
    for (k = 0; k < 21 * 6 && word_out === CODE_ZERO; k++) @(negedge clk_sys);
    chk("nonzero", {15'h0, word_out === CODE_ZERO}, 16'h0000);
    for (k = k; k < 57 * 6 && settled !== 1'b1; k++) @(negedge clk_sys);
    chk("settle", {15'h0, k >= 54 * 6 && k < 57 * 6}, 16'h0001);
  endtask
  task automatic t_word(logic signed [15:0] s, logic [15:0] w, logic f);
    mod_sample = s;
    wait_falls(4);
    chk("word", got_word, w);
    chk("flag", {15'h0, got_flag}, {15'h0, f});
  endtask
  task automatic t_oe();
    for (int i = 0; i < 4; i++) begin
      cs_req = i[0];
      rd_req = i[1];
      repeat (3) @(negedge clk_sys);
      chk("oe", word_oe_n, (i == 3) ? 16'h0000 : 16'hFFFF);
    end
  endtask
  task automatic t_pd();
    int f;
    power_down_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    f = n_falls;
    repeat (12) @(negedge clk_sys);
    chk("saving", {15'h0, saving}, 16'h0001);
    chk("halted", {15'h0, n_falls == f && strobe_n === 1'b1}, 16'h0001);
    power_down_n = 1'b1;
    wait_falls(2);
    chk("resettle", {15'h0, settled}, 16'h0000);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, sync_n, power_down_n, cs_req, rd_req} = 5'h0E;
    mod_sample = 16'sh0000;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_settle();
    t_oe();
    t_word(16'sh0001, 16'h0006, 1'b0);
    t_word(-16'sh0002, 16'hFFF4, 1'b0);
    t_word(16'sh7FFF, CODE_MAX, 1'b1);
    t_word(16'sh0001, 16'h0006, 1'b0);
    t_word(-16'sh8000, CODE_MIN, 1'b1);
    t_settle();
    t_pd();
    final_report();
  end
endmodule

// ---- logic/aops_buf2.sv ----
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes the filling side holds data stable while valid and not ready.
*/
module aops_buf2 #(
  parameter int W = 17
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_reg [2];
  logic [W-1:0] mem_next [2];
  logic         rd_reg, rd_next, wr_reg, wr_next;
  logic [1:0]   cnt_reg, cnt_next;
  logic         push, pop;

  // pointer and count update; full when both entries hold words
  always_comb begin
    push     = in_valid && (cnt_reg != 2'h2);
    pop      = out_ready && (cnt_reg != 2'h0);
    mem_next = mem_reg;
    if (push) begin
      mem_next[wr_reg] = in_data;
    end
    wr_next  = push ? ~wr_reg : wr_reg;
    rd_next  = pop ? ~rd_reg : rd_reg;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rd_reg];
endmodule

// ---- logic/aops_pkg.sv ----
/*
  Constants for the converter output port sequencer: decimation ratio,
  strobe phase lengths, settling counts and code limits.
  Assumes one clock (clk_sys) that doubles as the conversion clock.
*/
// Operation
// - one sample per clock, decimate by six
// - ready strobe three clocks high, three low
// - sync low forces output word to zero
// - non-zero words within twenty-one ready cycles
// - words valid from fifty-five ready cycles on
// - bus released when read or select high
// - bus driven only when both are low
// - each result is a sixteen-bit parallel word
// - over-range flag high beyond full scale
// - power-down low halts conversion, saves power
// - falling ready edge marks each new word
// - sync clears state; first fall second edge
// - two's complement, clip to limits, flag set
// - over-range flag updates on ready falling edge
package aops_pkg;
  localparam int          WORD_W        = 16;
  localparam int          ACC_W         = 24;
  localparam int          DECIM         = 6;
  localparam int          HALF_PERIOD   = 3;
  localparam int          PHASE_W       = 3;
  localparam logic [2:0]  PHASE_FIRST   = 3'h2;
  localparam int          NONZERO_WORDS = 21;
  localparam int          SETTLE_WORDS  = 55;
  localparam int          CNT_W         = 6;
  localparam logic [15:0] CODE_MAX      = 16'h7FFF;
  localparam logic [15:0] CODE_MIN      = 16'h8000;
  localparam logic [15:0] CODE_ZERO     = 16'h0000;
endpackage

// ---- logic/aops_seq.sv ----
/*
  Output port sequencer: decimates modulator samples by six, clips to
  sixteen-bit two's complement, strobes each word with an active-low ready,
  and drives the word bus when select and read are both low.

  Groups of state, each with its own next-value logic and register:
    - sequencer state: idle, run and sleep; power-down parks it in sleep
    - phase counter: position inside the six-clock word period
    - accumulator: plain sum of six samples (four for the first word after release or wake), restarted every word
    - ready strobe: three clocks low from the fall, three clocks high
    - word and flag: loaded together from the buffer at each fall
    - settle counter: counts ready falls since sync release or wake
    - output enables: one per bus bit, a clock behind select and read

  A two-entry buffer sits between the accumulator and the output word so
  that the sixth-sample push and the later fall never fight over a word.
  The very first fall after release finds the buffer empty and keeps the
  zero word; the first sum appears at the following fall.

  Timing after sync release: the first edge enters run with the phase
  preloaded, the second edge drops the ready strobe. Falls then come every
  six clocks.

  Limitations: no filter taps, so the settle flag is a count of falls and
  not a measure of filter error; the bus itself is left to the pad ring,
  this block only gives per-bit enables.

  Assumes modulator samples are synchronous to clk_sys; sync_n acts as the
  asynchronous reset of the digital path together with rst_n.
*/
module aops_seq
  import aops_pkg::*;
#(
  parameter int SAMPLE_W = 4
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      sync_n,
  input  wire logic                      power_down_n,
  input  wire logic signed [SAMPLE_W-1:0] mod_sample,
  input  wire logic                      chip_select_n,
  input  wire logic                      read_enable_n,
  output logic [aops_pkg::WORD_W-1:0]    word_out,
  output logic [aops_pkg::WORD_W-1:0]    word_oe_n,
  output logic                           word_ready_strobe_n,
  output logic                           over_range_flag,
  output logic                           word_settled,
  output logic                           power_saving
);
  import aops_pkg::*;

  typedef enum logic [2:0] {
    AOPS_IDLE = 3'b001,
    AOPS_RUN  = 3'b010,
    AOPS_SLEEP = 3'b100
  } aops_state_t;

  // combined async clear: sync low clears everything
  logic arst_n;
  assign arst_n = rst_n & sync_n;

  aops_state_t             state_reg, state_next;
  logic [PHASE_W-1:0]      phase_reg, phase_next;
  logic signed [ACC_W-1:0] acc_reg, acc_next;
  logic [WORD_W-1:0]       word_reg, word_next;
  logic [WORD_W-1:0]       oe_reg, oe_next;
  logic                    strobe_reg, strobe_next;
  logic                    ovr_reg, ovr_next;
  logic [CNT_W-1:0]        cnt_reg, cnt_next;
  logic                    settled_reg, settled_next;
  logic                    sleep_reg, sleep_next;

  // buffer handshake signals
  logic                    buf_in_valid, buf_in_ready;
  logic [WORD_W:0]         buf_in_data, buf_out_data;
  logic                    buf_out_valid, buf_out_ready;
  logic signed [ACC_W-1:0] acc_sum;
  logic [WORD_W-1:0]       clip_word;
  logic                    clip_ovr;
  logic                    fall_now;
  logic                    run_go;
  logic                    wake_now;
  logic                    end_of_word;
  logic                    bus_read;

  // clip the decimated sum to the sixteen-bit range
  function automatic logic [WORD_W:0] aops_clip(input logic signed [ACC_W-1:0] v);
    logic [WORD_W:0] r;
    r = '0;
    if (v > $signed({{(ACC_W-WORD_W){1'b0}}, CODE_MAX})) begin
      r = {1'b1, CODE_MAX}; // clip positive
    end else if (v < $signed({{(ACC_W-WORD_W){1'b1}}, CODE_MIN})) begin
      r = {1'b1, CODE_MIN}; // clip negative
    end else begin
      r = {1'b0, v[WORD_W-1:0]};
    end
    return r;
  endfunction

  // one sample per clock added into the accumulator
  assign acc_sum   = acc_reg + ACC_W'(mod_sample);
  assign {clip_ovr, clip_word} = aops_clip(acc_sum);
  assign fall_now  = run_go && (phase_reg == PHASE_W'(HALF_PERIOD - 1));

  // mode and phase decodes shared by several groups
  assign run_go      = (state_reg == AOPS_RUN) && power_down_n;
  assign wake_now    = (state_reg == AOPS_SLEEP) && power_down_n;
  assign end_of_word = (phase_reg == PHASE_W'(DECIM - 1));
  assign bus_read    = !chip_select_n && !read_enable_n;

  // a finished word is pushed on the sixth sample
  assign buf_in_valid = run_go && end_of_word;
  assign buf_in_data  = {clip_ovr, clip_word};
  // word leaves the buffer at the ready fall
  assign buf_out_ready = fall_now;

  aops_buf2 #(
    .W(WORD_W + 1)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (arst_n),
    .in_data   (buf_in_data),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready)
  );

  // sequencer state; power-down parks it, a wake passes through idle
  always_comb begin
    state_next = state_reg;
    sleep_next = sleep_reg;
    unique case (state_reg)
      AOPS_IDLE: begin
        state_next = AOPS_RUN;
      end
      AOPS_RUN: begin
        if (!power_down_n) begin
          state_next = AOPS_SLEEP; // halt conversion
          sleep_next = 1'b1;
        end
      end
      AOPS_SLEEP: begin
        if (power_down_n) begin
          state_next = AOPS_IDLE;
          sleep_next = 1'b0;
        end
      end
      default: begin
        state_next = AOPS_IDLE; // stray code: restart cleanly
        sleep_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= AOPS_IDLE;
      sleep_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sleep_reg <= sleep_next;
    end
  end

  // phase counter; idle preloads so the first fall is on edge two
  always_comb begin
    phase_next = phase_reg;
    if (state_reg == AOPS_IDLE) begin
      phase_next = PHASE_FIRST;
    end else if (run_go) begin
      phase_next = end_of_word ? '0 : phase_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // accumulator; restarts each sixth sample, cleared on wake
  always_comb begin
    acc_next = acc_reg;
    if (wake_now) begin
      acc_next = '0;
    end else if (run_go) begin
      acc_next = buf_in_valid ? '0 : acc_sum;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ready strobe: three low from the fall, three high
  always_comb begin
    strobe_next = strobe_reg;
    if ((state_reg == AOPS_RUN) && !power_down_n) begin
      strobe_next = 1'b1; // parked high while asleep
    end else if (fall_now) begin
      strobe_next = 1'b0;
    end else if (run_go && end_of_word) begin
      strobe_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strobe_reg <= 1'b1; // ready forced high
    end else begin
      strobe_reg <= strobe_next;
    end
  end

  // word and flag move together, only at a fall
  always_comb begin
    word_next = word_reg;
    ovr_next  = ovr_reg;
    if (fall_now && buf_out_valid) begin
      word_next = buf_out_data[WORD_W-1:0]; // new 16-bit word
      ovr_next  = buf_out_data[WORD_W];     // clip marker
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      word_reg <= CODE_ZERO; // zero word during sync
      ovr_reg  <= 1'b0;
    end else begin
      word_reg <= word_next;
      ovr_reg  <= ovr_next;
    end
  end

  // settle counter counts falls and saturates; a wake restarts it
  always_comb begin
    cnt_next     = cnt_reg;
    settled_next = settled_reg;
    if (wake_now) begin
      cnt_next     = '0;
      settled_next = 1'b0;
    end else if (fall_now) begin
      if (cnt_reg != CNT_W'(SETTLE_WORDS)) begin
        cnt_next = cnt_reg + 1'b1;
      end
      settled_next = (cnt_reg >= CNT_W'(SETTLE_WORDS - 1));
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg     <= '0;
      settled_reg <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      settled_reg <= settled_next;
    end
  end

  // one enable per bus bit; low drives, only with both strobes low
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++) begin : g_oe
      assign oe_next[gi] = ~bus_read;
    end
  endgenerate

  // registered so the pad enables never glitch with select decoding
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe_reg <= '1;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // all outputs straight from flip-flops; host reads after fall
  assign word_out            = word_reg;
  assign word_oe_n           = oe_reg;
  assign word_ready_strobe_n = strobe_reg;
  assign over_range_flag     = ovr_reg;
  assign word_settled        = settled_reg;
  assign power_saving        = sleep_reg;
endmodule
